// File: dv/core_pipe_model.sv
/*
 Pipeline model: drives core events, ALU and multiply requests.
 Assumes the register bank on the same clock, inputs sampled at rising edges.
*/
`timescale 1ns/10ps
module core_pipe_model (
   input wire logic clk_sys,
   input wire logic early_exit_pulse,
   output core_regs_pkg::core_evt_t evt,
   output core_regs_pkg::alu_req_t alu_req,
   output core_regs_pkg::mul_req_t mul_req
);
   import core_regs_pkg::*;
   initial begin
      evt = '0;
      alu_req = '0;
      mul_req = '0;
   end
   // Innermost DO loop ends after early exit
   always @(posedge clk_sys) begin
      if (early_exit_pulse === 1'b1 && evt.nest_depth != 3'h0) begin
         evt.nest_depth <= evt.nest_depth - 3'h1;
         evt.do_active <= (evt.nest_depth > 3'h1);
      end
   end
   task automatic evt_cycle(input core_evt_t v);
      @(posedge clk_sys);
      evt <= v;
      @(posedge clk_sys);
      {v.ovf_a, v.ovf_b, v.clip_a, v.clip_b} = 4'h0;
      {v.sfa_set, v.sfa_clr, v.pri_wr} = 3'h0;
      evt <= v;
   endtask
   task automatic alu_op(input alu_op_t op, input logic byt,
                         input logic [15:0] a, input logic [15:0] b);
      @(posedge clk_sys);
      alu_req <= '{1'b1, op, byt, a, b, 16'h0000};
      @(posedge clk_sys);
      alu_req.valid <= 1'b0;
   endtask
   task automatic mul_op(input mul_mode_t m, input logic [15:0] a,
                         input logic [15:0] b);
      @(posedge clk_sys);
      mul_req <= '{1'b1, m, a, b};
      @(posedge clk_sys);
      mul_req.valid <= 1'b0;
   endtask
endmodule

// File: dv/tb.sv
/*
 Self-checking bench for the core status and control register bank.
 Assumes an AHB-Lite slave with no wait states and the pipeline model.
*/
`timescale 1ns/10ps
module tb;
   import core_regs_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic early_exit_pulse;
   logic page_bypass;
   logic [15:0] alu_result;
   logic [31:0] mul_result;
   core_evt_t evt;
   alu_req_t alu_req;
   mul_req_t mul_req;
   core_cfg_t cfg;
   core_evt_t ev;
   logic [31:0] rd;
   int error_cnt = 0;
   int n_compared = 0;
   int exit_cnt = 0;
   logic [33:0] alu_tbl [5] = '{{2'h0, 16'h7FFF, 16'h0001},
      {2'h0, 16'hFFFF, 16'h0001}, {2'h2, 16'h0000, 16'h0001},
      {2'h1, 16'h000F, 16'h0001}, {2'h3, 16'h0080, 16'h0001}};

   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (early_exit_pulse === 1'b1) exit_cnt++;
   end

   cpu_status_core_control u_cpu_status_core_control (
      .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(), .evt(evt), .alu_req(alu_req), .mul_req(mul_req),
      .cfg(cfg), .early_exit_pulse(early_exit_pulse),
      .alu_result(alu_result), .mul_result(mul_result),
      .page_bypass(page_bypass));
   core_pipe_model u_core_pipe_model (
      .clk_sys(clk_sys), .early_exit_pulse(early_exit_pulse),
      .evt(evt), .alu_req(alu_req), .mul_req(mul_req));

   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, {16'h0000, d});
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      bus(1'b0, a, 32'h00000000);
      check(rd, {16'h0000, e});
   endtask
   task automatic evc(input core_evt_t v);
      u_core_pipe_model.evt_cycle(v);
      repeat (2) @(posedge clk_sys);
   endtask
   function automatic logic [20:0] alu_exp(input logic sub, input logic byt,
                                           input logic [15:0] a, input logic [15:0] b);
      logic [15:0] bb;
      logic [16:0] s;
      logic [8:0] s8;
      logic [4:0] h;
      bb = sub ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + 17'(sub);
      s8 = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + 9'(sub);
      h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(sub);
      if (byt) return {s[15:0], h[4], s8[7], a[7] == bb[7] && s8[7] != a[7],
                       s8[7:0] == 8'h00, s8[8]};
      return {s[15:0], s8[8], s[15], a[15] == bb[15] && s[15] != a[15],
              s[15:0] == 16'h0000, s[16]};
   endfunction
   function automatic logic [31:0] mul_exp(input int m, input logic [15:0] a,
                                           input logic [15:0] b);
      logic [16:0] x;
      logic [16:0] y;
      logic signed [33:0] p;
      x = {(m == 0 || m == 2 || m == 4) & a[15], a};
      y = {(m == 0 || m == 3) & b[15], b};
      if (m >= 4) y = {12'h000, b[4:0]};
      if (m == 6) x = {9'h000, a[7:0]};
      if (m == 6) y = {9'h000, b[7:0]};
      p = $signed(x) * $signed(y);
      return p[31:0];
   endfunction

   task automatic t_reset;
      rc(STATUS_OFS, 16'h0000);
      rc(CONTROL_OFS, 16'h0020);
      wr(8'h40, 16'hFFFF);
      rc(8'h40, 16'h0000);
      check({31'h0, cfg.store_clip_enable}, 32'h1);
   endtask
   task automatic t_acc;
      ev = '0;
      ev.ovf_a = 1'b1;
      ev.clip_b = 1'b1;
      evc(ev);
      rc(STATUS_OFS, 16'h9C00);
      wr(STATUS_OFS, 16'h1400);
      rc(STATUS_OFS, 16'h1400);
      wr(STATUS_OFS, 16'h0000);
      rc(STATUS_OFS, 16'h0000);
      ev = '0;
      ev.ovf_b = 1'b1;
      ev.clip_a = 1'b1;
      evc(ev);
      rc(STATUS_OFS, 16'h6C00);
      wr(STATUS_OFS, 16'h0000);
   endtask
   task automatic t_loop;
      ev = '0;
      ev.do_active = 1'b1;
      ev.rep_active = 1'b1;
      ev.nest_depth = 3'h2;
      evc(ev);
      wr(STATUS_OFS, 16'h0000);
      rc(STATUS_OFS, 16'h0210);
      rc(CONTROL_OFS, 16'h0220);
      wr(CONTROL_OFS, 16'hA8F3);
      rc(CONTROL_OFS, 16'hA1F3);
      check(exit_cnt, 32'h1);
      check({22'h0, cfg.latency_var, cfg.multiply_sign_select,
             cfg.acc_a_clip_enable, cfg.acc_b_clip_enable,
             cfg.store_clip_enable, cfg.clip_width_select,
             cfg.round_select, cfg.int_mode}, 32'h1BF);
      for (int i = 0; i < 3; i++) begin
         wr(CONTROL_OFS, {2'h0, 2'(i), 12'h000});
         rc(CONTROL_OFS, {2'h0, 2'(i), 12'h100});
         check({30'h0, cfg.multiply_sign_select}, i);
      end
      evc('0);
   endtask
   task automatic t_prio;
      wr(STATUS_OFS, 16'h00E0);
      rc(PRIORITY_OFS, 16'h0007);
      check({27'h0, cfg.cpu_priority, cfg.user_int_disable}, 32'hF);
      wr(STATUS_OFS, 16'h0060);
      check({27'h0, cfg.cpu_priority, cfg.user_int_disable}, 32'h6);
      ev = '0;
      ev.pri_wr = 1'b1;
      ev.pri_val = 4'hA;
      evc(ev);
      rc(PRIORITY_OFS, 16'h000A);
      rc(STATUS_OFS, 16'h0040);
      check({27'h0, cfg.cpu_priority, cfg.user_int_disable}, 32'h15);
      ev = '0;
      ev.nesting_disable = 1'b1;
      evc(ev);
      wr(STATUS_OFS, 16'h00E0);
      rc(STATUS_OFS, 16'h0040);
      ev.sfa_set = 1'b1;
      evc(ev);
      rc(CONTROL_OFS, 16'h200C);
      check({31'h0, page_bypass}, 32'h1);
      wr(CONTROL_OFS, 16'h0000);
      rc(CONTROL_OFS, 16'h0004);
      ev = '0;
      ev.sfa_clr = 1'b1;
      evc(ev);
      check({31'h0, page_bypass}, 32'h0);
   endtask
   task automatic t_alu;
      logic [20:0] e;
      for (int i = 0; i < 5; i++) begin
         e = alu_exp(alu_tbl[i][33], alu_tbl[i][32], alu_tbl[i][31:16],
                     alu_tbl[i][15:0]);
         u_core_pipe_model.alu_op(alu_tbl[i][33] ? ALU_SUB : ALU_ADD,
            alu_tbl[i][32], alu_tbl[i][31:16], alu_tbl[i][15:0]);
         bus(1'b0, STATUS_OFS, 32'h00000000);
         check(rd & 32'h010F, {23'h0, e[4], 4'h0, e[3:0]});
         if (!alu_tbl[i][32]) check({16'h0, alu_result}, {16'h0, e[20:5]});
      end
   endtask
   task automatic t_mul;
      for (int i = 0; i < 7; i++) begin
         u_core_pipe_model.mul_op(mul_mode_t'(i), 16'h8003, 16'hFFF5);
         @(posedge clk_sys);
         check(mul_result, mul_exp(i, 16'h8003, 16'hFFF5));
      end
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset;
      t_acc;
      t_loop;
      t_prio;
      t_alu;
      t_mul;
      print_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      print_verdict;
   end
endmodule

// File: logic/core_regs_pkg.sv
/*
 Package for the core status and core control register bank: AHB offsets,
 bit positions, reset values, ALU and multiplier encodings, carrier structs.
 Assumes a 32-bit AHB-Lite bus with one aligned word per register.
*/
package core_regs_pkg;
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] CONTROL_OFS = 8'h04;
   localparam logic [7:0] PRIORITY_OFS = 8'h08;
   localparam logic [7:0] ALU_RES_OFS = 8'h0C;
   localparam logic [7:0] MUL_RES_OFS = 8'h10;

   localparam int ST_OA = 15;
   localparam int ST_OB = 14;
   localparam int ST_SA = 13;
   localparam int ST_SB = 12;
   localparam int ST_OAB = 11;
   localparam int ST_SAB = 10;
   localparam int ST_DA = 9;
   localparam int ST_DC = 8;
   localparam int ST_IPL_LO = 5;
   localparam int ST_RA = 4;
   localparam int ST_N = 3;
   localparam int ST_OV = 2;
   localparam int ST_Z = 1;
   localparam int ST_C = 0;

   localparam int CC_LAT = 15;
   localparam int CC_US_LO = 12;
   localparam int CC_EDT = 11;
   localparam int CC_DL_LO = 8;
   localparam int CC_ACC_A_CLIP_ENABLE = 7;
   localparam int CC_ACC_B_CLIP_ENABLE = 6;
   localparam int CC_STORE_CLIP_ENABLE = 5;
   localparam int CC_CLIP_WIDTH_SELECT = 4;
   localparam int CC_CPU_PRIORITY_BIT3 = 3;
   localparam int CC_SFA = 2;
   localparam int CC_RND = 1;
   localparam int CC_IF = 0;

   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_RESET = 16'h0020;
   // Bits software may write directly in the control register
   localparam logic [15:0] CONTROL_WMASK = 16'hB0F3;

   localparam logic [1:0] SIGN_SIGNED = 2'h0;
   localparam logic [1:0] SIGN_UNSIGNED = 2'h1;
   localparam logic [1:0] SIGN_MIXED = 2'h2;

   typedef enum logic [2:0] {
      MUL_SS = 3'h0,
      MUL_UU = 3'h1,
      MUL_SU = 3'h2,
      MUL_US = 3'h3,
      MUL_SLIT = 3'h4,
      MUL_ULIT = 3'h5,
      MUL_BYTE = 3'h6
   } mul_mode_t;

   typedef enum logic [1:0] {
      ALU_ADD = 2'h0,
      ALU_SUB = 2'h1,
      ALU_LOGIC = 2'h2
   } alu_op_t;

   typedef struct packed {
      logic valid;
      alu_op_t op;
      logic byte_op;
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] logic_res;
   } alu_req_t;

   typedef struct packed {
      logic valid;
      mul_mode_t mode;
      logic [15:0] a;
      logic [15:0] b;
   } mul_req_t;

   typedef struct packed {
      logic ovf_a;
      logic ovf_b;
      logic clip_a;
      logic clip_b;
      logic do_active;
      logic rep_active;
      logic [2:0] nest_depth;
      logic sfa_set;
      logic sfa_clr;
      logic nesting_disable;
      logic pri_wr;
      logic [3:0] pri_val;
   } core_evt_t;

   typedef struct packed {
      logic latency_var;
      logic [1:0] multiply_sign_select;
      logic early_loop_exit;
      logic acc_a_clip_enable;
      logic acc_b_clip_enable;
      logic store_clip_enable;
      logic clip_width_select;
      logic frame_active_flag;
      logic round_select;
      logic int_mode;
      logic [3:0] cpu_priority;
      logic user_int_disable;
   } core_cfg_t;
endpackage

// File: logic/cpu_status_core_control.sv
/*
 Core status and core control register bank with ALU flag generation and
 the MCU multiplier. Assumes an AHB-Lite master for software access and a
 pipeline that reports accumulator and loop events as synchronous levels.
*/
// How it works
// - Accumulator overflow sets status bits 15 and 14.
// - Clip sticky bits 13 and 12 set on saturation and stay set.
// - Bit 11 reads as OR of overflows and can be cleared.
// - Bit 10 reads OR of stickies; writing zero clears both stickies.
// - Bit 9 shows DO loop active, bit 4 REPEAT active, read-only.
// - Nibble carry from bit 3 for bytes, bit 7 for words.
// - Priority is control bit 3 above status 7:5; bit 3 blocks user ints.
// - Status priority bits read-only while nesting disable is set.
// - Priority 7 (value 111) also disables user interrupts.
// - Multiplier does signed, unsigned, mixed, literal and byte modes.
// - Negative flag follows the result sign.
// - Signed overflow flag sets when the sign wraps.
// - Zero flag cleared by nonzero result, set by zero result.
// - Carry from result msb, borrow sense for subtraction.
// - Control bit 15 selects variable latency, resets to zero.
// - Control bits 13:12 select multiply sign mode; 14 reserved.
// - Writing one to bit 11 ends the DO loop; reads as zero.
// - Control bits 10:8 report DO nesting depth, read-only.
// - Bits 7,6 enable accumulator clipping; bit 5 store clip, resets one.
// - Bit 4 selects 9.31 clipping when one, 1.31 when zero.
// - Frame flag makes frame and stack pointers ignore the page regs.
// - Bit 1 selects biased rounding, bit 0 integer multiply.
`timescale 1ns/10ps
module cpu_status_core_control (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire core_regs_pkg::core_evt_t evt,
   input wire core_regs_pkg::alu_req_t alu_req,
   input wire core_regs_pkg::mul_req_t mul_req,
   output core_regs_pkg::core_cfg_t cfg,
   output logic early_exit_pulse,
   output logic [15:0] alu_result,
   output logic [31:0] mul_result,
   output logic page_bypass
);
   import core_regs_pkg::*;

   function automatic logic [16:0] ext17(input logic [15:0] v,
                                         input logic sgn);
      ext17 = {sgn & v[15], v};
   endfunction

   logic [15:0] status_q, status_d;
   logic [15:0] control_q, control_d;
   logic [15:0] alu_res_q;
   logic [31:0] mul_res_q;
   logic wr_pend_q, rd_pend_q;
   logic [7:0] addr_q;
   logic [31:0] hrdata_q;
   logic exit_q;
   core_cfg_t cfg_q;

   // Address phase capture
   wire addr_ok = hsel & hready & htrans[1];
   wire wr_st = wr_pend_q & (addr_q == STATUS_OFS);
   wire wr_cc = wr_pend_q & (addr_q == CONTROL_OFS);
   wire wr_pri = wr_pend_q & (addr_q == PRIORITY_OFS);
   wire [15:0] wd = hwdata[15:0];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok & hwrite;
         rd_pend_q <= addr_ok & ~hwrite;
         addr_q <= addr_ok ? haddr : addr_q;
      end
   end

   // ALU arithmetic with carry chain
   wire sub = (alu_req.op == ALU_SUB);
   wire [15:0] b_eff = sub ? ~alu_req.b : alu_req.b;
   wire [16:0] sum = {1'b0, alu_req.a} + {1'b0, b_eff} + {16'h0000, sub};
   wire [15:0] cin_vec = alu_req.a ^ b_eff ^ sum[15:0];
   wire arith = (alu_req.op != ALU_LOGIC);
   wire [15:0] res = arith ? sum[15:0] : alu_req.logic_res;
   wire res_msb = alu_req.byte_op ? res[7] : res[15];
   wire res_zero = alu_req.byte_op ? (res[7:0] == 8'h00) : (res == 16'h0000);
   wire carry_out = alu_req.byte_op ? cin_vec[8] : sum[16];
   wire nib_carry = alu_req.byte_op ? cin_vec[4] : cin_vec[8];
   wire a_msb = alu_req.byte_op ? alu_req.a[7] : alu_req.a[15];
   wire b_msb = alu_req.byte_op ? b_eff[7] : b_eff[15];
   wire sgn_wrap = (a_msb == b_msb) & (res_msb != a_msb);

   // Multiplier operand shaping, 17 by 17 signed core
   logic [16:0] ma, mb;
   always_comb begin
      ma = ext17(mul_req.a, 1'b1);
      mb = ext17(mul_req.b, 1'b1);
      case (mul_req.mode)
         MUL_SS: begin
            ma = ext17(mul_req.a, 1'b1);
            mb = ext17(mul_req.b, 1'b1);
         end
         MUL_UU: begin
            ma = ext17(mul_req.a, 1'b0);
            mb = ext17(mul_req.b, 1'b0);
         end
         MUL_SU: begin
            ma = ext17(mul_req.a, 1'b1);
            mb = ext17(mul_req.b, 1'b0);
         end
         MUL_US: begin
            ma = ext17(mul_req.a, 1'b0);
            mb = ext17(mul_req.b, 1'b1);
         end
         MUL_SLIT: begin
            ma = ext17(mul_req.a, 1'b1);
            mb = {12'h000, mul_req.b[4:0]};
         end
         MUL_ULIT: begin
            ma = ext17(mul_req.a, 1'b0);
            mb = {12'h000, mul_req.b[4:0]};
         end
         MUL_BYTE: begin
            ma = {9'h000, mul_req.a[7:0]};
            mb = {9'h000, mul_req.b[7:0]};
         end
         default: begin
            ma = ext17(mul_req.a, 1'b1);
            mb = ext17(mul_req.b, 1'b1);
         end
      endcase
   end
   wire signed [33:0] prod = $signed(ma) * $signed(mb);

   // Status register next value
   wire ipl_locked = evt.nesting_disable;
   always_comb begin
      status_d = status_q;
      if (wr_st) begin
         status_d[ST_OA] = wd[ST_OA];
         status_d[ST_OB] = wd[ST_OB];
         status_d[ST_SA] = wd[ST_SA];
         status_d[ST_SB] = wd[ST_SB];
         if (!wd[ST_OAB]) begin
            status_d[ST_OA] = 1'b0;
            status_d[ST_OB] = 1'b0;
         end
         if (!wd[ST_SAB]) begin
            status_d[ST_SA] = 1'b0;
            status_d[ST_SB] = 1'b0;
         end
         status_d[ST_DC] = wd[ST_DC];
         status_d[ST_N] = wd[ST_N];
         status_d[ST_OV] = wd[ST_OV];
         status_d[ST_Z] = wd[ST_Z];
         status_d[ST_C] = wd[ST_C];
         if (!ipl_locked)
            status_d[ST_IPL_LO +: 3] = wd[ST_IPL_LO +: 3];
      end
      if (evt.pri_wr)
         status_d[ST_IPL_LO +: 3] = evt.pri_val[2:0];
      // Hardware events win over a software clear
      if (evt.ovf_a)
         status_d[ST_OA] = 1'b1;
      if (evt.ovf_b)
         status_d[ST_OB] = 1'b1;
      if (evt.clip_a)
         status_d[ST_SA] = 1'b1;
      if (evt.clip_b)
         status_d[ST_SB] = 1'b1;
      if (alu_req.valid) begin
         status_d[ST_N] = res_msb;
         status_d[ST_Z] = res_zero;
         if (arith) begin
            status_d[ST_C] = carry_out;
            status_d[ST_DC] = nib_carry;
            status_d[ST_OV] = sgn_wrap;
         end
      end
      status_d[ST_DA] = evt.do_active;
      status_d[ST_RA] = evt.rep_active;
      status_d[ST_OAB] = status_d[ST_OA] | status_d[ST_OB];
      status_d[ST_SAB] = status_d[ST_SA] | status_d[ST_SB];
   end

   // Control register next value
   always_comb begin
      control_d = control_q;
      if (wr_cc)
         control_d = (control_q & ~CONTROL_WMASK) | (wd & CONTROL_WMASK);
      if (evt.pri_wr)
         control_d[CC_CPU_PRIORITY_BIT3] = evt.pri_val[3];
      else if (wr_cc && !wd[CC_CPU_PRIORITY_BIT3])
         control_d[CC_CPU_PRIORITY_BIT3] = 1'b0;
      if (evt.sfa_set)
         control_d[CC_SFA] = 1'b1;
      else if (evt.sfa_clr)
         control_d[CC_SFA] = 1'b0;
      control_d[CC_DL_LO +: 3] = evt.nest_depth;
      control_d[CC_EDT] = 1'b0;
      control_d[14] = 1'b0;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         status_q <= STATUS_RESET;
         control_q <= CONTROL_RESET;
      end else begin
         status_q <= status_d;
         control_q <= control_d;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         alu_res_q <= 16'h0000;
         mul_res_q <= 32'h0000_0000;
      end else begin
         alu_res_q <= alu_req.valid ? res : alu_res_q;
         mul_res_q <= mul_req.valid ? prod[31:0] : mul_res_q;
      end
   end

   // Configuration fan-out, registered
   wire [3:0] pri_full = {control_d[CC_CPU_PRIORITY_BIT3], status_d[ST_IPL_LO +: 3]};
   wire edt_req = wr_cc & wd[CC_EDT];
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cfg_q <= '0;
         cfg_q.store_clip_enable <= 1'b1;
         exit_q <= 1'b0;
      end else begin
         cfg_q.latency_var <= control_d[CC_LAT];
         cfg_q.multiply_sign_select <= control_d[CC_US_LO +: 2];
         cfg_q.early_loop_exit <= edt_req;
         cfg_q.acc_a_clip_enable <= control_d[CC_ACC_A_CLIP_ENABLE];
         cfg_q.acc_b_clip_enable <= control_d[CC_ACC_B_CLIP_ENABLE];
         cfg_q.store_clip_enable <= control_d[CC_STORE_CLIP_ENABLE];
         cfg_q.clip_width_select <= control_d[CC_CLIP_WIDTH_SELECT];
         cfg_q.frame_active_flag <= control_d[CC_SFA];
         cfg_q.round_select <= control_d[CC_RND];
         cfg_q.int_mode <= control_d[CC_IF];
         cfg_q.cpu_priority <= pri_full;
         cfg_q.user_int_disable <= pri_full[3] |
            (pri_full[2:0] == 3'h7);
         exit_q <= edt_req;
      end
   end

   // Read mux, bits above 15 read as zero except for the 32-bit multiply result
   wire [31:0] rd_mux =
      (haddr == STATUS_OFS) ? {16'h0000, status_q} :
      (haddr == CONTROL_OFS) ? {16'h0000, control_q} :
      (haddr == PRIORITY_OFS) ? {28'h0000000, cfg_q.cpu_priority} :
      (haddr == ALU_RES_OFS) ? {16'h0000, alu_res_q} :
      (haddr == MUL_RES_OFS) ? mul_res_q : 32'h0000_0000;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         hrdata_q <= 32'h0000_0000;
      else if (addr_ok & ~hwrite)
         hrdata_q <= rd_mux;
   end

   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign cfg = cfg_q;
   assign early_exit_pulse = exit_q;
   assign alu_result = alu_res_q;
   assign mul_result = mul_res_q;
   assign page_bypass = cfg_q.frame_active_flag;

   property p_ovf_a;
      @(posedge clk_sys) disable iff (reset)
      evt.ovf_a |=> status_q[ST_OA] & status_q[ST_OAB];
   endproperty
   a_ovf_a: assert property (p_ovf_a) else $error("ovf A lost");

   property p_sticky;
      @(posedge clk_sys) disable iff (reset)
      $rose(status_q[ST_SA]) & ~wr_st |=> status_q[ST_SA];
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky dropped");

   property p_oab;
      @(posedge clk_sys) disable iff (reset)
      status_q[ST_OAB] == (status_q[ST_OA] | status_q[ST_OB]);
   endproperty
   a_oab: assert property (p_oab) else $error("oab mismatch");

   property p_sab_clr;
      @(posedge clk_sys) disable iff (reset)
      wr_st & ~wd[ST_SAB] & ~evt.clip_a & ~evt.clip_b |=>
         ~status_q[ST_SA] & ~status_q[ST_SB] & ~status_q[ST_SAB];
   endproperty
   a_sab_clr: assert property (p_sab_clr) else $error("sab clear");

   property p_loop;
      @(posedge clk_sys) disable iff (reset)
      ##1 status_q[ST_DA] == $past(evt.do_active);
   endproperty
   a_loop: assert property (p_loop) else $error("loop flag");

   property p_edt;
      @(posedge clk_sys) disable iff (reset)
      edt_req |=> early_exit_pulse ##1 ~control_q[CC_EDT];
   endproperty
   a_edt: assert property (p_edt) else $error("early exit");

   property p_zero;
      @(posedge clk_sys) disable iff (reset)
      alu_req.valid & ~res_zero |=> ~status_q[ST_Z];
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag");

   property p_ipl_lock;
      @(posedge clk_sys) disable iff (reset)
      wr_st & ipl_locked & ~evt.pri_wr |=>
         status_q[7:5] == $past(status_q[7:5]);
   endproperty
   a_ipl_lock: assert property (p_ipl_lock) else $error("ipl lock");

   property p_uid;
      @(posedge clk_sys) disable iff (reset)
      cfg.cpu_priority[3] |-> cfg.user_int_disable;
   endproperty
   a_uid: assert property (p_uid) else $error("user int");

   c_clip: cover property (@(posedge clk_sys) evt.clip_a ##1 wr_st);
   c_edt: cover property (@(posedge clk_sys) edt_req);
   c_wrap: cover property (@(posedge clk_sys) alu_req.valid & sgn_wrap);
endmodule
